// ### pkg/cstm_pkg.sv
// package: register map, field layout, reset values and timing for the can status/timing block
package cstm_pkg;
	// register word indices; the apb byte address is the index times four
	localparam logic [7:0] CSTM_IDX_CTRL      = 8'h00;
	localparam logic [7:0] CSTM_IDX_STATUS    = 8'h02;
	localparam logic [7:0] CSTM_IDX_TEC       = 8'h04;
	localparam logic [7:0] CSTM_IDX_REC       = 8'h05;
	localparam logic [7:0] CSTM_IDX_BTL       = 8'h06;
	localparam logic [7:0] CSTM_IDX_BTH       = 8'h07;
	localparam logic [7:0] CSTM_IDX_INTL      = 8'h08;
	localparam logic [7:0] CSTM_IDX_INTH      = 8'h09;
	localparam logic [7:0] CSTM_IDX_PRESCALER_EXT_FIELD      = 8'h0c;
	localparam logic [7:0] CSTM_IDX_IF1_CREQL = 8'h10;
	localparam logic [7:0] CSTM_IDX_IF1_CREQH = 8'h11;
	localparam logic [7:0] CSTM_IDX_IF2_CREQL = 8'h12;
	localparam logic [7:0] CSTM_IDX_IF2_CREQH = 8'h13;
	localparam int         CSTM_ADDR_SHIFT    = 2;

	// control register bits
	localparam int CSTM_CTRL_INIT = 0;
	localparam int CSTM_CTRL_IE   = 1;
	localparam int CSTM_CTRL_SIE  = 2;
	localparam int CSTM_CTRL_EIE  = 3;
	localparam int CSTM_CTRL_CCE  = 6;
	localparam logic [7:0] CSTM_CTRL_RST = 8'h01;

	// status register bits
	localparam int CSTM_ST_TX_SUCCESS_FLAG  = 3;
	localparam int CSTM_ST_RX_SUCCESS_FLAG  = 4;
	localparam int CSTM_ST_ERROR_PASSIVE_FLAG = 5;
	localparam int CSTM_ST_ERROR_WARNING_FLAG = 6;
	localparam int CSTM_ST_BUS_OFF_FLAG  = 7;

	// last error codes
	localparam logic [2:0] CSTM_LEC_NONE  = 3'h0;
	localparam logic [2:0] CSTM_LEC_FORM  = 3'h2;
	localparam logic [2:0] CSTM_LEC_ACK   = 3'h3;
	localparam logic [2:0] CSTM_LEC_BIT1  = 3'h4;
	localparam logic [2:0] CSTM_LEC_BIT0  = 3'h5;
	localparam logic [2:0] CSTM_LEC_CRC   = 3'h6;
	localparam logic [2:0] CSTM_LEC_NOCHG = 3'h7;

	localparam logic [15:0] CSTM_INTERRUPT_SOURCE_ID_STATUS = 16'h8000;

	// bit timing fields and reset values
	localparam int CSTM_SJW_LSB  = 6;
	localparam int CSTM_TSG2_LSB = 4;
	localparam logic [7:0] CSTM_BTL_RST  = 8'h01;
	localparam logic [7:0] CSTM_BTH_RST  = 8'h23;
	localparam logic [7:0] CSTM_BTH_MASK = 8'h7f;
	localparam logic [7:0] CSTM_PRESCALER_EXT_FIELD_MASK = 8'h0f;

	// error counter levels
	localparam logic [8:0] CSTM_PASSIVE_LVL = 9'd128;
	localparam logic [8:0] CSTM_WARN_LVL    = 9'd96;
	localparam logic [8:0] CSTM_BUS_OFF_FLAG_LVL    = 9'd256;
	localparam logic [3:0] CSTM_RECESSIVE_RUN = 4'd11;

	// message ram transfer timing
	localparam logic [2:0] CSTM_XFER_CYCLES = 3'd4;
	localparam logic [5:0] CSTM_MSG_LAST    = 6'h20;
endpackage

// ### core/cstm_ifset.sv
// one interface buffer set: command request, busy flag, message ram transfer slot
`timescale 1ns/1ps
`default_nettype none
module cstm_ifset
	import cstm_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_req_wr,
	input  wire logic [5:0] i_req_num,
	input  wire logic       i_grant,
	output logic            o_want,
	output logic            o_busy,
	output logic [5:0]      o_obj
);
	typedef struct packed {
		logic       busy;
		logic       granted;
		logic [2:0] cnt;
		logic [5:0] obj;
	} cstm_if_state_t;

	cstm_if_state_t st;
	cstm_if_state_t next_st;

	always_comb begin
		next_st = st;
		if (i_req_wr && !st.busy) begin
			next_st.busy    = 1'b1;
			next_st.granted = 1'b0;
			next_st.cnt     = 3'd0;
			// fold invalid numbers onto objects 1..32
			if (i_req_num == 6'h00)
				next_st.obj = CSTM_MSG_LAST;
			else if (i_req_num > CSTM_MSG_LAST)
				next_st.obj = i_req_num - CSTM_MSG_LAST;
			else
				next_st.obj = i_req_num;
		end else if (st.busy) begin
			if (!st.granted) begin
				// wait for arbitration; the count runs from the request, so a late grant shortens the ram access
				if (i_grant)
					next_st.granted = 1'b1;
				next_st.cnt = st.cnt + 3'd1;
			end else begin
				next_st.cnt = st.cnt + 3'd1;
				if (st.cnt >= CSTM_XFER_CYCLES) begin
					next_st.busy    = 1'b0;
					next_st.granted = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_want = st.busy && !st.granted;
	assign o_busy = st.busy;
	assign o_obj  = st.obj;
endmodule
`default_nettype wire

// ### core/cstm_core.sv
// can status, error counters, bit timing and interface command request block with apb slave
`timescale 1ns/1ps
`default_nettype none
module cstm_core
	import cstm_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	input  wire logic        i_ev_form_err,
	input  wire logic        i_ev_ack_err,
	input  wire logic        i_ev_bit1_err,
	input  wire logic        i_ev_bit0_err,
	input  wire logic        i_ev_crc_err,
	input  wire logic        i_ev_rx_ok,
	input  wire logic        i_ev_tx_ok,
	input  wire logic        i_ev_tec_inc,
	input  wire logic        i_ev_rec_inc,
	input  wire logic        i_ev_recessive_bit,
	input  wire logic        i_mh_ram_req,
	output logic             o_mh_ram_grant,
	output logic             o_wait_n,
	output logic             o_status_irq,
	output logic [9:0]       o_tq_div,
	output logic [1:0]       o_sjw_tq,
	output logic [3:0]       o_seg_before_tq,
	output logic [2:0]       o_seg_after_tq,
	output logic [5:0]       o_if1_obj,
	output logic [5:0]       o_if2_obj,
	output logic             o_tq_tick
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [2:0]  last_error_code_field;
		logic        tx_success_flag;
		logic        rx_success_flag;
		logic        bus_off_flag;
		logic        error_warning_flag;
		logic [8:0]  tx_error_count;
		logic [7:0]  rx_error_count;
		logic [7:0]  bit_timing_low;
		logic [7:0]  bit_timing_high;
		logic [7:0]  prescaler_extension;
		logic        status_pend;
		logic [3:0]  rec_run;
		logic [9:0]  tq_cnt;
		logic        tq_tick;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        wait_n;
		logic        irq;
		logic        mh_grant;
	} cstm_state_t;

	cstm_state_t st;
	cstm_state_t next_st;

	logic       if1_wr;
	logic       if2_wr;
	logic       if1_want;
	logic       if2_want;
	logic       if1_busy;
	logic       if2_busy;
	logic       if1_grant;
	logic       if2_grant;
	logic [5:0] if1_obj;
	logic [5:0] if2_obj;
	logic       setup;
	logic       wr_acc;
	logic       rd_acc;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic       bus_ev;
	logic       rx_passive_flag;
	logic       timing_open;
	logic [9:0] tq_div;

	assign setup  = i_psel && !i_penable;
	assign idx    = {2'b00, i_paddr[7:CSTM_ADDR_SHIFT]};
	assign wr_acc = setup && i_pwrite;
	assign rd_acc = setup && !i_pwrite;
	assign wbyte  = i_pwdata[7:0];
	assign if1_wr = wr_acc && idx == CSTM_IDX_IF1_CREQL;
	assign if2_wr = wr_acc && idx == CSTM_IDX_IF2_CREQL;

	// ram arbiter: interface sets first, message handler takes leftover slots
	assign if1_grant = if1_want && !st.mh_grant;
	assign if2_grant = if2_want && !if1_want && !st.mh_grant;

	cstm_ifset u_if1 (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_req_wr  (if1_wr),
		.i_req_num (wbyte[5:0]),
		.i_grant   (if1_grant),
		.o_want    (if1_want),
		.o_busy    (if1_busy),
		.o_obj     (if1_obj)
	);

	cstm_ifset u_if2 (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_req_wr  (if2_wr),
		.i_req_num (wbyte[5:0]),
		.i_grant   (if2_grant),
		.o_want    (if2_want),
		.o_busy    (if2_busy),
		.o_obj     (if2_obj)
	);

	assign rx_passive_flag = {1'b0, st.rx_error_count} >= CSTM_PASSIVE_LVL;
	assign timing_open = st.ctrl[CSTM_CTRL_CCE] && st.ctrl[CSTM_CTRL_INIT];
	assign tq_div = {st.prescaler_extension[3:0], st.bit_timing_low[5:0]};
	assign bus_ev = i_ev_form_err || i_ev_ack_err || i_ev_bit1_err || i_ev_bit0_err
		|| i_ev_crc_err || i_ev_rx_ok || i_ev_tx_ok;

	always_comb begin
		next_st = st;
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.mh_grant = i_mh_ram_req && !if1_want && !if2_want;

		// software writes; they never raise the status interrupt
		if (wr_acc) begin
			next_st.pready = 1'b1;
			case (idx)
				CSTM_IDX_CTRL: begin
					next_st.ctrl = wbyte;
				end
				CSTM_IDX_STATUS: begin
					next_st.last_error_code_field = wbyte[2:0];
					next_st.tx_success_flag = wbyte[CSTM_ST_TX_SUCCESS_FLAG];
					next_st.rx_success_flag = wbyte[CSTM_ST_RX_SUCCESS_FLAG];
				end
				CSTM_IDX_BTL: begin
					if (timing_open)
						next_st.bit_timing_low = wbyte;
				end
				CSTM_IDX_BTH: begin
					if (timing_open)
						next_st.bit_timing_high = wbyte & CSTM_BTH_MASK;
				end
				CSTM_IDX_PRESCALER_EXT_FIELD: begin
					if (timing_open)
						next_st.prescaler_extension = wbyte & CSTM_PRESCALER_EXT_FIELD_MASK;
				end
				CSTM_IDX_TEC, CSTM_IDX_REC, CSTM_IDX_INTL, CSTM_IDX_INTH,
				CSTM_IDX_IF1_CREQL, CSTM_IDX_IF1_CREQH,
				CSTM_IDX_IF2_CREQL, CSTM_IDX_IF2_CREQH: begin
					next_st.pslverr = 1'b0;
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		if (rd_acc) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0000_0000;
			case (idx)
				CSTM_IDX_CTRL: next_st.prdata[7:0] = st.ctrl;
				CSTM_IDX_STATUS: begin
					next_st.prdata[7:0] = {st.bus_off_flag, st.error_warning_flag,
						({1'b0, st.tx_error_count} >= {1'b0, CSTM_PASSIVE_LVL}) || rx_passive_flag,
						st.rx_success_flag, st.tx_success_flag, st.last_error_code_field};
					next_st.status_pend = 1'b0;
				end
				CSTM_IDX_TEC: next_st.prdata[7:0] = st.tx_error_count[7:0];
				CSTM_IDX_REC: next_st.prdata[7:0] = {rx_passive_flag, st.rx_error_count[6:0]};
				CSTM_IDX_BTL: next_st.prdata[7:0] = st.bit_timing_low;
				CSTM_IDX_BTH: next_st.prdata[7:0] = st.bit_timing_high;
				CSTM_IDX_INTL: next_st.prdata[7:0] = st.status_pend ? CSTM_INTERRUPT_SOURCE_ID_STATUS[7:0] : 8'h00;
				CSTM_IDX_INTH: next_st.prdata[7:0] = st.status_pend ? CSTM_INTERRUPT_SOURCE_ID_STATUS[15:8] : 8'h00;
				CSTM_IDX_PRESCALER_EXT_FIELD: next_st.prdata[7:0] = st.prescaler_extension;
				CSTM_IDX_IF1_CREQL: next_st.prdata[7:0] = {2'b00, if1_obj};
				CSTM_IDX_IF1_CREQH: next_st.prdata[7:0] = {if1_busy, 7'h00};
				CSTM_IDX_IF2_CREQL: next_st.prdata[7:0] = {2'b00, if2_obj};
				CSTM_IDX_IF2_CREQH: next_st.prdata[7:0] = {if2_busy, 7'h00};
				default: next_st.pslverr = 1'b1;
			endcase
		end

		// protocol events override a same-cycle software write
		if (i_ev_form_err)
			next_st.last_error_code_field = CSTM_LEC_FORM;
		else if (i_ev_ack_err)
			next_st.last_error_code_field = CSTM_LEC_ACK;
		else if (i_ev_bit1_err)
			next_st.last_error_code_field = CSTM_LEC_BIT1;
		else if (i_ev_bit0_err)
			next_st.last_error_code_field = CSTM_LEC_BIT0;
		else if (i_ev_crc_err)
			next_st.last_error_code_field = CSTM_LEC_CRC;
		else if (i_ev_rx_ok || i_ev_tx_ok)
			next_st.last_error_code_field = CSTM_LEC_NONE;
		if (i_ev_rx_ok)
			next_st.rx_success_flag = 1'b1;
		if (i_ev_tx_ok)
			next_st.tx_success_flag = 1'b1;

		// recessive run counting while recovering from bus-off or in init
		if (st.bus_off_flag || st.ctrl[CSTM_CTRL_INIT]) begin
			if (i_ev_recessive_bit) begin
				if (st.rec_run == CSTM_RECESSIVE_RUN - 4'd1) begin
					next_st.rec_run = 4'd0;
					next_st.last_error_code_field = CSTM_LEC_BIT0;
					if (st.bus_off_flag) begin
						next_st.tx_error_count = 9'd0;
						next_st.rx_error_count = 8'd0;
					end
				end else begin
					next_st.rec_run = st.rec_run + 4'd1;
				end
			end
		end else begin
			next_st.rec_run = 4'd0;
		end

		// simplified confinement counting
		if (i_ev_tec_inc && st.tx_error_count < CSTM_BUS_OFF_FLAG_LVL)
			next_st.tx_error_count = st.tx_error_count + 9'd8;
		else if (i_ev_tx_ok && st.tx_error_count != 9'd0)
			next_st.tx_error_count = st.tx_error_count - 9'd1;
		if (i_ev_rec_inc && st.rx_error_count != 8'hff)
			next_st.rx_error_count = st.rx_error_count + 8'd1;
		else if (i_ev_rx_ok && st.rx_error_count != 8'd0)
			next_st.rx_error_count = st.rx_error_count - 8'd1;
		next_st.bus_off_flag = next_st.tx_error_count >= CSTM_BUS_OFF_FLAG_LVL;
		next_st.error_warning_flag = next_st.tx_error_count >= CSTM_WARN_LVL
			|| {1'b0, next_st.rx_error_count} >= CSTM_WARN_LVL;

		// status interrupt; set wins over the read clear
		if (st.ctrl[CSTM_CTRL_IE]) begin
			if (st.ctrl[CSTM_CTRL_EIE] && (next_st.bus_off_flag != st.bus_off_flag
				|| next_st.error_warning_flag != st.error_warning_flag))
				next_st.status_pend = 1'b1;
			if (st.ctrl[CSTM_CTRL_SIE] && bus_ev)
				next_st.status_pend = 1'b1;
		end
		next_st.irq = next_st.status_pend;

		// time quantum tick generator
		if (st.tq_cnt >= tq_div) begin
			next_st.tq_cnt  = 10'd0;
			next_st.tq_tick = 1'b1;
		end else begin
			next_st.tq_cnt  = st.tq_cnt + 10'd1;
			next_st.tq_tick = 1'b0;
		end

		// the wait output follows either busy set, including the one just requested
		next_st.wait_n = !(if1_busy || if2_busy || if1_wr || if2_wr);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			st <= '0;
			st.ctrl <= CSTM_CTRL_RST;
			st.bit_timing_low <= CSTM_BTL_RST;
			st.bit_timing_high <= CSTM_BTH_RST;
			st.wait_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_pready        = st.pready;
	assign o_prdata        = st.prdata;
	assign o_pslverr       = st.pslverr;
	assign o_mh_ram_grant  = st.mh_grant;
	assign o_wait_n        = st.wait_n;
	assign o_status_irq    = st.irq;
	assign o_tq_div        = tq_div;
	assign o_sjw_tq        = st.bit_timing_low[7:CSTM_SJW_LSB];
	assign o_seg_before_tq = st.bit_timing_high[3:0];
	assign o_seg_after_tq  = st.bit_timing_high[6:CSTM_TSG2_LSB];
	assign o_if1_obj       = if1_obj;
	assign o_if2_obj       = if2_obj;
	assign o_tq_tick       = st.tq_tick;
endmodule
`default_nettype wire

// ### sim/cstm_props.sv
// assertion checker for the can status, timing and command request block
`timescale 1ns/1ps
`default_nettype none
module cstm_props
	import cstm_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic        o_pready,
	input  wire logic        o_pslverr,
	input  wire logic        o_wait_n,
	input  wire logic        o_status_irq,
	input  wire logic [9:0]  o_tq_div,
	input  wire logic        o_tq_tick,
	input  wire logic [5:0]  o_if1_obj,
	input  wire logic        i_mh_ram_req,
	input  wire logic        o_mh_ram_grant
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	localparam logic [7:0] A_ST  = 8'h08;
	localparam logic [7:0] A_IF1 = 8'h40;
	logic setup;
	assign setup = i_psel && !i_penable;
	function automatic logic [5:0] fold(input logic [5:0] d);
		return (d == 6'h00) ? 6'h20 : ((d > 6'h20) ? d - 6'h20 : d);
	endfunction
	sequence s_low3;
		!o_wait_n [*3];
	endsequence
	sequence s_wr_if1;
		setup && i_pwrite && i_paddr == A_IF1 && o_wait_n;
	endsequence
	property p_ready;
		setup |=> o_pready;
	endproperty
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	property p_wait;
		s_wr_if1 |=> !o_wait_n;
	endproperty
	property p_wlen;
		$fell(o_wait_n) |-> s_low3 ##[1:12] o_wait_n;
	endproperty
	property p_tick;
		o_tq_tick && o_tq_div == 10'd1 && !i_psel |=> !o_tq_tick ##1 o_tq_tick;
	endproperty
	property p_clr;
		setup && !i_pwrite && i_paddr == A_ST |-> ##[1:2] !o_status_irq;
	endproperty
	property p_nowr;
		setup && i_pwrite && i_paddr == A_ST && !o_status_irq |=> !o_status_irq [*3];
	endproperty
	property p_obj;
		s_wr_if1 |=> o_if1_obj == fold($past(i_pwdata[5:0]));
	endproperty
	property p_grant;
		i_mh_ram_req |-> ##[0:12] o_mh_ram_grant;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	a_err:   assert property (p_err) else $error("slave error without ready");
	a_wait:  assert property (p_wait) else $error("wait not raised");
	a_wlen:  assert property (p_wlen) else $error("wait window wrong");
	a_tick:  assert property (p_tick) else $error("quantum tick spacing wrong");
	a_clr:   assert property (p_clr) else $error("status read kept irq");
	a_nowr:  assert property (p_nowr) else $error("status write raised irq");
	a_obj:   assert property (p_obj) else $error("object number not folded");
	a_grant: assert property (p_grant) else $error("handler starved");
endmodule
`default_nettype wire

// ### sim/cstm_mh_model.sv
// message handler stand-in: asks once for the message ram, frees it after one granted cycle
`timescale 1ns/1ps
`default_nettype none
module cstm_mh_model (
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	input  wire logic i_want,
	input  wire logic i_grant,
	output logic      o_req,
	output logic      o_got
);
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_req <= 1'b0;
			o_got <= 1'b0;
		end else if (o_req && i_grant) begin
			o_req <= 1'b0;
			o_got <= 1'b1;
		end else if (i_want && !o_got) begin
			o_req <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### sim/tb.sv
// testbench for the can status, timing and command request block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cstm_pkg::*;
	logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
	logic        i_pwrite = 1'b0, want = 1'b0, se, got;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, r;
	logic        o_pready, o_pslverr, i_mh_ram_req, o_mh_ram_grant, o_wait_n;
	logic        o_status_irq, o_tq_tick;
	logic [9:0]  o_tq_div, ev = 10'h000;
	logic [1:0]  o_sjw_tq;
	logic [3:0]  o_seg_before_tq;
	logic [2:0]  o_seg_after_tq;
	logic [5:0]  o_if1_obj, o_if2_obj;
	int          err_count = 0, n_compared = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	cstm_core u_cstm_core (.*, .i_ev_form_err(ev[0]), .i_ev_ack_err(ev[1]),
		.i_ev_bit1_err(ev[2]), .i_ev_bit0_err(ev[3]), .i_ev_crc_err(ev[4]),
		.i_ev_rx_ok(ev[5]), .i_ev_tx_ok(ev[6]), .i_ev_tec_inc(ev[7]),
		.i_ev_rec_inc(ev[8]), .i_ev_recessive_bit(ev[9]));
	cstm_mh_model u_cstm_mh_model (.i_sys_clk, .i_resetn, .i_want(want),
		.i_grant(o_mh_ram_grant), .o_req(i_mh_ram_req), .o_got(got));
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			err_count++;
			$display("FAIL %0t wait ran out", $time);
			complete_run();
		end
	endtask
	// request held from setup edge until the edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge i_sys_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= 8'(idx << CSTM_ADDR_SHIFT);
		i_pwdata <= {24'h0, d};
		@(posedge i_sys_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		tmo(n, 20);
		r = o_prdata;
		se = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx);
		apb(1'b0, idx, 8'h00);
	endtask
	task automatic pulse(input int k, input int times);
		repeat (times) begin
			@(posedge i_sys_clk);
			ev <= 10'(1 << k);
			@(posedge i_sys_clk);
			ev <= 10'h000;
		end
		repeat (3) @(posedge i_sys_clk);
	endtask
	// waits for the edge that samples wait or tick high, as selected
	task automatic wait_for(input logic tick, output int n);
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while ((tick ? o_tq_tick : o_wait_n) !== 1'b1 && n < 1100);
		tmo(n, 1100);
	endtask
	task automatic t_reset;
		rd(CSTM_IDX_BTL);
		chk(r, 32'h01);
		rd(CSTM_IDX_BTH);
		chk(r, 32'h23);
		rd(CSTM_IDX_PRESCALER_EXT_FIELD);
		chk(r, 32'h00);
		chk1(se, 1'b0);
		chk(32'(o_tq_div), 32'h1);
		rd(8'h3f);
		chk1(se, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_timing;
		int n;
		wr(CSTM_IDX_BTL, 8'hc5);
		rd(CSTM_IDX_BTL);
		chk(r, 32'h01);
		wr(CSTM_IDX_CTRL, 8'h41);
		wr(CSTM_IDX_BTL, 8'hc5);
		wr(CSTM_IDX_BTH, 8'hff);
		wr(CSTM_IDX_PRESCALER_EXT_FIELD, 8'h0f);
		rd(CSTM_IDX_BTH);
		chk(r, 32'h7f);
		chk(32'(o_sjw_tq), 32'h3);
		chk(32'(o_seg_before_tq), 32'hf);
		chk(32'(o_seg_after_tq), 32'h7);
		chk(32'(o_tq_div), 32'h3c5);
		wait_for(1'b1, n);
		wait_for(1'b1, n);
		chk(32'(n), 32'd966);
		wr(CSTM_IDX_CTRL, 8'h40);
		wr(CSTM_IDX_BTL, 8'h00);
		rd(CSTM_IDX_BTL);
		chk(r, 32'hc5);
		$display("test timing done");
	endtask
	task automatic t_status;
		wr(CSTM_IDX_CTRL, 8'h06);
		for (int k = 0; k < 5; k++) begin
			pulse(k, 1);
			chk1(o_status_irq, 1'b1);
			rd(CSTM_IDX_STATUS);
			chk(r & 32'h7, 32'(k + 2));
			repeat (3) @(posedge i_sys_clk);
			chk1(o_status_irq, 1'b0);
		end
		pulse(5, 1);
		rd(CSTM_IDX_INTH);
		chk(r, 32'h80);
		rd(CSTM_IDX_STATUS);
		chk(r & 32'h1f, 32'h10);
		rd(CSTM_IDX_INTH);
		chk(r, 32'h00);
		wr(CSTM_IDX_STATUS, 8'h07);
		repeat (3) @(posedge i_sys_clk);
		chk1(o_status_irq, 1'b0);
		rd(CSTM_IDX_STATUS);
		chk(r & 32'h7, 32'h7);
		pulse(6, 1);
		chk1(o_status_irq, 1'b1);
		rd(CSTM_IDX_STATUS);
		chk(r & 32'h1f, 32'h08);
		$display("test status done");
	endtask
	task automatic t_counters;
		wr(CSTM_IDX_CTRL, 8'h0a);
		pulse(7, 12);
		chk1(o_status_irq, 1'b1);
		rd(CSTM_IDX_STATUS);
		chk(r & 32'h60, 32'h40);
		pulse(7, 4);
		chk1(o_status_irq, 1'b0);
		rd(CSTM_IDX_TEC);
		chk(r, 32'h80);
		pulse(8, 127);
		rd(CSTM_IDX_REC);
		chk(r, 32'h7f);
		pulse(8, 1);
		rd(CSTM_IDX_REC);
		chk(r & 32'h80, 32'h80);
		pulse(5, 1);
		rd(CSTM_IDX_REC);
		chk(r, 32'h7f);
		// ten recessive bits in init wait leave the code alone, the eleventh rewrites it
		wr(CSTM_IDX_CTRL, 8'h01);
		pulse(9, 10);
		rd(CSTM_IDX_STATUS);
		chk(r & 32'h7, 32'h0);
		pulse(9, 1);
		rd(CSTM_IDX_STATUS);
		chk(r & 32'h7, 32'h5);
		$display("test counters done");
	endtask
	task automatic t_creq;
		logic [5:0] v[5] = '{6'h00, 6'h01, 6'h20, 6'h21, 6'h3f};
		logic [5:0] e[5] = '{6'h20, 6'h01, 6'h20, 6'h01, 6'h1f};
		int n;
		for (int i = 0; i < 5; i++) begin
			wr(CSTM_IDX_IF1_CREQL, {2'b00, v[i]});
			rd(CSTM_IDX_IF1_CREQH);
			chk(r & 32'h80, 32'h80);
			wait_for(1'b0, n);
			chk(32'(o_if1_obj), 32'(e[i]));
			rd(CSTM_IDX_IF1_CREQH);
			chk(r & 32'h80, 32'h00);
		end
		// handler and set one race for the ram, set two asks once set one is done; the second set-one write hits a busy set
		want <= 1'b1;
		wr(CSTM_IDX_IF1_CREQL, 8'h05);
		wr(CSTM_IDX_IF1_CREQL, 8'h07);
		wr(CSTM_IDX_IF2_CREQL, 8'h25);
		wait_for(1'b0, n);
		chk(32'(o_if1_obj), 32'h05);
		chk(32'(o_if2_obj), 32'h05);
		chk1(got, 1'b1);
		want <= 1'b0;
		$display("test command request done");
	endtask
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_timing();
		t_status();
		t_counters();
		t_creq();
		complete_run();
	end
endmodule
bind cstm_core cstm_props u_cstm_props (.*);
`default_nettype wire
